//--- logic/pmwm_mapper.v
`timescale 1ns/1ps
`include "pmwm_regs.vh"

// paged memory window mapper with apb registers
module pmwm_mapper (
  input wire ref_clk,             // system clock
  input wire nrst,                // synchronous reset, low
  input wire psel,                // apb select
  input wire penable,             // apb access phase
  input wire pwrite,              // apb direction
  input wire [11:0] paddr,        // apb byte address
  input wire [31:0] pwdata,       // apb write data
  output wire pready,             // apb ready
  output reg [31:0] prdata,       // apb read data
  output reg pslverr,             // apb error
  input wire [15:0] cpu_addr,     // cpu address
  input wire vector_fetch,        // cpu fetches reset vector
  input wire int_space_hit,       // regs, ram or eeprom here
  input wire rom_space_hit,       // on-chip rom here
  output reg [15:0] ext_addr,     // address to external bus
  output reg int_sel,             // internal resource answers
  output reg rom_sel,             // on-chip rom answers
  output reg ext_sel,             // external memory answers
  output reg win1_active,         // window 1 owns access
  output reg win2_active,         // window 2 owns access
  input wire [5:0] pg_in,         // port pins in
  output reg [5:0] pg_out,        // port pins out
  output reg [5:0] pg_oe          // port pins drive enable
);

  // ****************************************************
  // register storage
  // ****************************************************
  reg [5:0] pin_assign_reg;     // 1 makes pin an expansion line
  reg [3:0] window_size_reg;    // both size fields
  reg [6:0] window_base_reg;    // both base fields
  reg [5:0] window1_bank_reg;   // window 1 bank
  reg [5:0] window2_bank_reg;   // window 2 bank
  reg [5:0] gpio_data;          // port output data
  reg [5:0] gpio_dir;           // port direction, 1 drives
  reg [2:0] mem_ctrl;           // rom enable, rom low, expand
  reg [5:0] pg_s1;              // pin sync stage 1
  reg [5:0] pg_s2;              // pin sync stage 2
  reg [5:0] pg_s3;              // pin sync stage 3
  reg [5:0] pg_stable;          // filtered port input

  // ****************************************************
  // field views
  // ****************************************************
  wire [1:0] window1_size_field;  // window 1 size
  wire [1:0] window2_size_field;  // window 2 size
  wire [2:0] window1_base_field;  // window 1 base
  wire [2:0] window2_base_field;  // window 2 base
  wire rom_en;                    // on-chip rom enabled
  wire rom_low;                   // rom mapped at 2000-7fff
  wire expand_en;                 // expanded memory enabled

  assign window1_size_field =
    window_size_reg[`PMWM_W1_SIZE_LSB +: 2];
  assign window2_size_field =
    window_size_reg[`PMWM_W2_SIZE_LSB +: 2];
  assign window1_base_field =
    window_base_reg[`PMWM_W1_BASE_LSB +: 3];
  assign window2_base_field =
    window_base_reg[`PMWM_W2_BASE_LSB +: 3];
  assign rom_en = mem_ctrl[`PMWM_CTRL_ROM_EN];
  assign rom_low = mem_ctrl[`PMWM_CTRL_ROM_LOW];
  assign expand_en = mem_ctrl[`PMWM_CTRL_EXPAND];

  // ****************************************************
  // apb helpers
  // ****************************************************
  // true when the bus address selects the given offset
  function addr_is;
    input [11:0] a;
    input [11:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  // true when the address hits any mapped register
  function addr_mapped;
    input [11:0] a;
    begin
      // word aligned and at or below the last register
      addr_mapped = (a[1:0] == 2'h0) && (a <= `PMWM_OFF_STATUS);
    end
  endfunction

  wire apb_setup;   // first cycle of a transfer
  wire apb_done;    // access completes this edge
  wire wr_ok;       // mapped write completes

  assign apb_setup = psel && !penable;
  // one wait-free access phase after setup
  assign pready = psel && penable;
  assign apb_done = psel && penable && pready;
  assign wr_ok = apb_done && pwrite && addr_mapped(paddr);

  // ****************************************************
  // window decoders
  // ****************************************************
  wire w1_hit;          // address inside window 1
  wire w2_hit;          // address inside window 2
  wire [5:0] w1_used;   // lines window 1 uses
  wire [5:0] w2_used;   // lines window 2 uses
  wire [5:0] w1_xa;     // window 1 line values
  wire [5:0] w2_xa;     // window 2 line values
  reg [15:0] eff_addr;  // address after vector steering

  // [RULE1] two independent windows
  pmwm_window u_win1 (
    .size(window1_size_field),
    .base(window1_base_field),
    .bank(window1_bank_reg),
    .addr(eff_addr),
    .hit(w1_hit),
    .used(w1_used),
    .xa_val(w1_xa),
    .inv14()
  );

  pmwm_window u_win2 (
    .size(window2_size_field),
    .base(window2_base_field),
    .bank(window2_bank_reg),
    .addr(eff_addr),
    .hit(w2_hit),
    .used(w2_used),
    .xa_val(w2_xa),
    .inv14()
  );

  // ****************************************************
  // reset vector steering
  // ****************************************************
  reg vec_ext;  // vector comes from external memory

  always @* begin
    eff_addr = cpu_addr;
    vec_ext = 1'b0;
    if (vector_fetch) begin
      if (expand_en) begin
        // [RULE13] expanded: external 7ffe-7fff
        eff_addr = `PMWM_VEC_EXP | {15'h0, cpu_addr[0]};
        vec_ext = 1'b1;
      end else begin
        // [RULE12] top of map, rom or external
        eff_addr = `PMWM_VEC_TOP | {15'h0, cpu_addr[0]};
        vec_ext = !rom_en || rom_low;
      end
    end
  end

  // ****************************************************
  // window priority and line selection
  // ****************************************************
  reg [5:0] act_used;  // lines used by owning window
  reg [5:0] act_xa;    // values from owning window
  reg [5:0] xa_line;   // final expansion line values
  reg in_win;          // some window owns the access
  integer i;

  always @* begin
    win1_active = 1'b0;
    win2_active = 1'b0;
    act_used = 6'h00;
    act_xa = 6'h00;
    // [RULE9] window 1 first, window 2 only outside it
    if (w1_hit) begin
      win1_active = 1'b1;
      act_used = w1_used;
      act_xa = w1_xa;
    end else if (w2_hit) begin
      win2_active = 1'b1;
      act_used = w2_used;
      act_xa = w2_xa;
    end
    in_win = win1_active || win2_active;
    for (i = 0; i < 6; i = i + 1) begin
      if (in_win && act_used[i]) begin
        // [RULE16] bank value on lines in window
        // [RULE2] bank number on expansion lines
        xa_line[i] = act_xa[i];
      end else if (i < 3) begin
        // [RULE17] unused low line carries cpu bit
        xa_line[i] = eff_addr[13 + i];
      end else begin
        // high line idle outside any window
        xa_line[i] = 1'b0;
      end
    end
  end

  // ****************************************************
  // external address and responder select
  // ****************************************************
  always @* begin
    ext_addr = eff_addr;
    // [RULE4] assigned low lines replace address 15:13
    if (pin_assign_reg[0])
      ext_addr[13] = xa_line[0];
    if (pin_assign_reg[1])
      ext_addr[14] = xa_line[1];
    if (pin_assign_reg[2])
      ext_addr[15] = xa_line[2];
    int_sel = 1'b0;
    rom_sel = 1'b0;
    if (vec_ext) begin
      // vector forced onto external memory
      int_sel = 1'b0;
    end else if (int_space_hit) begin
      // [RULE10] internal block wins in every bank
      int_sel = 1'b1;
    end else if (rom_space_hit && rom_en) begin
      // [RULE11] rom only where lines 18:16 are zero
      rom_sel = !in_win || (xa_line[5:3] == 3'h0);
    end
    ext_sel = !int_sel && !rom_sel;
  end

  // ****************************************************
  // port pin drive
  // ****************************************************
  always @* begin
    // [RULE3] unassigned pin is general purpose
    pg_oe = pin_assign_reg | gpio_dir;
    // [RULE17] assigned pin becomes expansion line
    pg_out = (pin_assign_reg & xa_line) | (gpio_data & ~pin_assign_reg);
  end

  // ****************************************************
  // port input synchroniser
  // ****************************************************
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pg_s1 <= 6'h00;
      pg_s2 <= 6'h00;
      pg_s3 <= 6'h00;
      pg_stable <= 6'h00;
    end else begin
      pg_s1 <= pg_in;
      pg_s2 <= pg_s1;
      pg_s3 <= pg_s2;
      // accept a level once stages 2 and 3 agree
      pg_stable <= (pg_s3 & ~(pg_s2 ^ pg_s3)) | (pg_stable & (pg_s2 ^ pg_s3));
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pin_assign_reg <= `PMWM_RST_PIN_ASSIGN;
      window_size_reg <= `PMWM_RST_WIN_SIZE;
      window_base_reg <= `PMWM_RST_WIN_BASE;
      window1_bank_reg <= `PMWM_RST_BANK;
      window2_bank_reg <= `PMWM_RST_BANK;
      gpio_data <= `PMWM_RST_GPIO;
      gpio_dir <= `PMWM_RST_GPIO;
      mem_ctrl <= `PMWM_RST_MEM_CTRL;
    end else if (wr_ok) begin
      if (addr_is(paddr, `PMWM_OFF_PIN_ASSIGN))
        pin_assign_reg <= pwdata[5:0];
      // [RULE14] two size fields
      if (addr_is(paddr, `PMWM_OFF_WIN_SIZE))
        window_size_reg <= pwdata[3:0];
      // [RULE15] two base fields
      if (addr_is(paddr, `PMWM_OFF_WIN_BASE))
        window_base_reg <= {pwdata[6:4], 1'b0, pwdata[2:0]};
      // [RULE16] new bank value switches banks
      if (addr_is(paddr, `PMWM_OFF_WIN1_BANK))
        window1_bank_reg <= pwdata[5:0];
      if (addr_is(paddr, `PMWM_OFF_WIN2_BANK))
        window2_bank_reg <= pwdata[5:0];
      if (addr_is(paddr, `PMWM_OFF_GPIO_DATA))
        gpio_data <= pwdata[5:0];
      if (addr_is(paddr, `PMWM_OFF_GPIO_DIR))
        gpio_dir <= pwdata[5:0];
      if (addr_is(paddr, `PMWM_OFF_MEM_CTRL))
        mem_ctrl <= pwdata[2:0];
    end
  end

  // ****************************************************
  // read data and error, captured in setup cycle
  // ****************************************************
  always @(posedge ref_clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !addr_mapped(paddr);
      prdata <= 32'h00000000;
      if (!pwrite) begin
        case (paddr)
          `PMWM_OFF_PIN_ASSIGN: prdata <= {26'h0, pin_assign_reg};
          `PMWM_OFF_WIN_SIZE: prdata <= {28'h0, window_size_reg};
          `PMWM_OFF_WIN_BASE: prdata <= {25'h0, window_base_reg};
          `PMWM_OFF_WIN1_BANK: prdata <= {26'h0, window1_bank_reg};
          `PMWM_OFF_WIN2_BANK: prdata <= {26'h0, window2_bank_reg};
          `PMWM_OFF_GPIO_DATA: prdata <= {26'h0, gpio_data};
          `PMWM_OFF_GPIO_DIR: prdata <= {26'h0, gpio_dir};
          `PMWM_OFF_MEM_CTRL: prdata <= {29'h0, mem_ctrl};
          // filtered pins and window ownership
          `PMWM_OFF_STATUS:
            prdata <= {24'h0, win2_active, win1_active, pg_stable};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

//--- logic/pmwm_regs.vh
// Functional notes
// [RULE1] one or two windows: off, 8, 16, 32k
// [RULE2] window hit drives bank number on lines
// [RULE3] unassigned port pins stay general purpose
// [RULE4] used low expansion lines replace address 15:13
// [RULE5] offset width and bank lines follow size
// [RULE6] software aligns base to size, 32k@4000
// [RULE7] 32k at 4000 drives inverted bit 14
// [RULE8] memory a14 wired to expansion line 14
// [RULE9] window 1 wins where windows overlap
// [RULE10] internal registers, ram, eeprom win every bank
// [RULE11] rom answers only in banks with top zero
// [RULE12] unexpanded vector from rom, else external top
// [RULE13] expanded mode fetches vector at 7ffe
// [RULE14] size field: off, 8k, 16k, 32k
// [RULE15] base field gives top three address bits
// [RULE16] bank register drives lines on window access
// [RULE17] assigned low line unused still outputs address
// [RULE18] decode same cycle, no wait states
`ifndef PMWM_REGS_VH
`define PMWM_REGS_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define PMWM_OFF_PIN_ASSIGN 12'h000
`define PMWM_OFF_WIN_SIZE 12'h004
`define PMWM_OFF_WIN_BASE 12'h008
`define PMWM_OFF_WIN1_BANK 12'h00c
`define PMWM_OFF_WIN2_BANK 12'h010
`define PMWM_OFF_GPIO_DATA 12'h014
`define PMWM_OFF_GPIO_DIR 12'h018
`define PMWM_OFF_MEM_CTRL 12'h01c
`define PMWM_OFF_STATUS 12'h020

// ****************************************************
// field positions
// ****************************************************
`define PMWM_W1_SIZE_LSB 0
`define PMWM_W2_SIZE_LSB 2
`define PMWM_W1_BASE_LSB 0
`define PMWM_W2_BASE_LSB 4
`define PMWM_CTRL_ROM_EN 0
`define PMWM_CTRL_ROM_LOW 1
`define PMWM_CTRL_EXPAND 2

// ****************************************************
// window size codes
// ****************************************************
`define PMWM_SIZE_OFF 2'h0
`define PMWM_SIZE_8K 2'h1
`define PMWM_SIZE_16K 2'h2
`define PMWM_SIZE_32K 2'h3

// ****************************************************
// reset values
// ****************************************************
`define PMWM_RST_PIN_ASSIGN 6'h00
`define PMWM_RST_WIN_SIZE 4'h0
`define PMWM_RST_WIN_BASE 7'h00
`define PMWM_RST_BANK 6'h00
`define PMWM_RST_GPIO 6'h00
`define PMWM_RST_MEM_CTRL 3'h1

// ****************************************************
// reset vector locations
// ****************************************************
`define PMWM_VEC_TOP 16'hfffe
`define PMWM_VEC_EXP 16'h7ffe

`endif

//--- logic/pmwm_window.v
`timescale 1ns/1ps
`include "pmwm_regs.vh"

// one address window: hit test and expansion line values
module pmwm_window (
  input wire [1:0] size,      // window size field
  input wire [2:0] base,      // window base field
  input wire [5:0] bank,      // bank register value
  input wire [15:0] addr,     // cpu address
  output reg hit,             // address falls in window
  output reg [5:0] used,      // expansion lines this window uses
  output reg [5:0] xa_val,    // value for expansion lines 18:13
  output reg inv14            // 32k window based at 4000
);

  // ****************************************************
  // combinational decode
  // ****************************************************
  // [RULE18] pure address decode
  always @* begin
    hit = 1'b0;
    used = 6'h00;
    inv14 = 1'b0;
    xa_val = bank;
    case (size)
      // [RULE14] size code 01: 8k
      `PMWM_SIZE_8K: begin
        // [RULE15] all three base bits count
        hit = (addr[15:13] == base);
        // [RULE5] offset 12:0, lines from 13 up
        used = 6'h3f;
      end
      `PMWM_SIZE_16K: begin
        // base rounds down to a 16k boundary
        hit = (addr[15:14] == base[2:1]);
        used = 6'h3e;
      end
      `PMWM_SIZE_32K: begin
        if (base[2:1] == 2'h1) begin
          // [RULE7] window spans 4000 to bfff
          hit = (addr[15:14] == 2'h1) || (addr[15:14] == 2'h2);
          inv14 = 1'b1;
          used = 6'h3e;
          xa_val = {bank[5:2], ~addr[14], bank[0]};
        end else begin
          hit = (addr[15] == base[2]);
          used = 6'h3c;
        end
      end
      default: begin
        // [RULE1] disabled window never hits
        hit = 1'b0;
      end
    endcase
  end

endmodule

//--- test/paged_memory_window_mapper_test.sv
`timescale 1ns/1ps
module paged_memory_window_mapper_test;
  reg ref_clk = 1'h0;                 // bench clock
  reg nrst = 1'h0;                    // reset, low
  reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb strobes
  reg [11:0] paddr = 12'h000;         // apb address
  reg [31:0] pwdata = 32'h0;          // apb data
  reg [15:0] cpu_addr = 16'h0;        // cpu address
  reg vector_fetch = 1'h0, int_space_hit = 1'h0, rom_space_hit = 1'h0;
  reg probe = 1'h0, split_14 = 1'h0;  // sample strobe, board wiring
  wire pready, pslverr, int_sel, rom_sel, ext_sel;
  wire win1_active, win2_active;
  wire [31:0] prdata;
  wire [15:0] ext_addr;
  wire [5:0] pg_in, pg_out, pg_oe;
  reg [63:0] notes[$];                // expected {mask, value}
  reg [63:0] note_exp;                // oldest note
  reg [31:0] note_act;                // observed result
  integer mismatches = 0, num_checks = 0, i;
  reg [31:0] seed = 32'h66edbcd4;     // lfsr state
  reg [1:0] sz1 = 2'h0, sz2 = 2'h0;   // bench copy of sizes
  reg [2:0] b1 = 3'h0, b2 = 3'h0;     // bench copy of bases
  reg [5:0] bk1 = 6'h0, bk2 = 6'h0, pa = 6'h0, gdir = 6'h0, gdata = 6'h0;
  reg [16:0] len;                     // window length
  reg [15:0] st;                      // window start
  localparam [63:0] RW_MASK = 64'h073f3f3f3f770f3f;
  localparam [79:0] A4K = 80'hc000bfff80007fff4000;
  localparam [15:0] VCTL = 16'h5301;
  localparam [47:0] VEXP = 48'h203207207407;

  always #5 ref_clk = ~ref_clk;

  pmwm_mapper i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cpu_addr(cpu_addr), .vector_fetch(vector_fetch),
    .int_space_hit(int_space_hit), .rom_space_hit(rom_space_hit),
    .ext_addr(ext_addr), .int_sel(int_sel), .rom_sel(rom_sel),
    .ext_sel(ext_sel), .win1_active(win1_active),
    .win2_active(win2_active), .pg_in(pg_in), .pg_out(pg_out),
    .pg_oe(pg_oe));
  pmwm_ext_mem i_mem (.ref_clk(ref_clk), .ext_addr(ext_addr),
    .pg_out(pg_out), .pg_oe(pg_oe), .split_14(split_14), .pg_in(pg_in),
    .phys_addr());

  // ****************************************************
  // helpers
  // ****************************************************
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one window: {hit, line values 18:13}
  function [6:0] win_model(input [1:0] sz, input [2:0] b,
    input [5:0] bk, input [15:0] a);
    reg [16:0] s, ln;
    reg [5:0] lo;
    begin
      ln = 17'h1000 << sz;
      lo = {2'h0, ln[16:13]} - 6'h1;
      s = {1'h0, b, 13'h0} & ~(ln - 17'h1);
      // 4000 window: bank starts at line 15
      if (sz == 2'h3 && b[2:1] == 2'h1) begin
        s = 17'h04000;
        lo = 6'h3;
      end
      win_model[6] = sz != 2'h0 && {1'h0, a} >= s && {1'h0, a} < s + ln;
      win_model[5:0] = (bk & ~lo) | ({3'h0, a[15:13]} & lo);
      if (sz == 2'h3 && b[2:1] == 2'h1) begin
        win_model[1] = ~a[14];
      end
    end
  endfunction
  // packed {pg_oe, wins, int/rom/ext, pg_out, ext_addr[15:13]}
  function [19:0] exp_all(input [15:0] a, input ih, input rh);
    reg [6:0] m1, m2;
    reg w1, w2;
    reg [5:0] ln;
    reg [2:0] sel;
    begin
      m1 = win_model(sz1, b1, bk1, a);
      m2 = win_model(sz2, b2, bk2, a);
      w1 = m1[6];
      w2 = m2[6] & ~w1;
      ln = w1 ? m1[5:0] : (w2 ? m2[5:0] : {3'h0, a[15:13]});
      if (ih) begin
        sel = 3'h4;
      end else if (rh && (!(w1 | w2) || ln[5:3] == 3'h0)) begin
        sel = 3'h2;
      end else begin
        sel = 3'h1;
      end
      exp_all = {pa | gdir, w1, w2, sel, (ln & pa) | (gdata & ~pa),
        ln[2:0]};
    end
  endfunction
  // apb transfer; a read notes its expected data
  task apb(input w, input [11:0] a, input [31:0] d, input [31:0] e);
    begin
      @(posedge ref_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) notes.push_back({32'hffffffff, e});
      @(posedge ref_clk);
      penable <= 1'h1;
      @(posedge ref_clk);
      while (pready !== 1'h1) @(posedge ref_clk);
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // drive the address path and note the expected outputs
  task chk(input [15:0] a, input vf, input ih, input rh,
    input [19:0] m, input [19:0] v);
    begin
      @(posedge ref_clk);
      cpu_addr <= a;
      vector_fetch <= vf;
      int_space_hit <= ih;
      rom_space_hit <= rh;
      probe <= 1'h1;
      notes.push_back({12'h0, m, 12'h0, v});
      @(posedge ref_clk);
      probe <= 1'h0;
    end
  endtask
  task chka(input [15:0] a, input ih, input rh);
    chk(a, 1'h0, ih, rh, 20'hfffff, exp_all(a, ih, rh));
  endtask
  task cfg(input [1:0] s1, input [2:0] c1, input [5:0] k1,
    input [1:0] s2, input [2:0] c2, input [5:0] k2);
    begin
      sz1 = s1;
      b1 = c1;
      bk1 = k1;
      sz2 = s2;
      b2 = c2;
      bk2 = k2;
      apb(1'h1, 12'h004, {28'h0, s2, s1}, 32'h0);
      apb(1'h1, 12'h008, {25'h0, c2, 1'h0, c1}, 32'h0);
      apb(1'h1, 12'h00c, {26'h0, k1}, 32'h0);
      apb(1'h1, 12'h010, {26'h0, k2}, 32'h0);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // ****************************************************
  // monitor: oldest note against each result
  // ****************************************************
  always @(posedge ref_clk) begin
    if (probe || (psel && penable && pready === 1'h1 && !pwrite)) begin
      note_act = probe ? {12'h0, pg_oe, win1_active, win2_active, int_sel,
        rom_sel, ext_sel, pg_out, ext_addr[15:13]} : prdata;
      note_exp = notes.pop_front();
      num_checks = num_checks + 1;
      if ((note_act & note_exp[63:32]) !==
          (note_exp[31:0] & note_exp[63:32])) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, note_act,
          note_exp[31:0]);
      end
    end
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    summarize;
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'h1;
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'h0, {i[9:0], 2'h0}, 32'h0, (i == 7) ? 32'h1 : 32'h0);
    end
    apb(1'h0, 12'h024, 32'h0, 32'h0);
    $display("reset values done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      apb(1'h1, {i[9:0], 2'h0}, seed, 32'h0);
      apb(1'h0, {i[9:0], 2'h0}, 32'h0, seed & RW_MASK[i*8 +: 8]);
    end
    $display("register access done");
    pa = 6'h3f;
    gdir = 6'h00;
    apb(1'h1, 12'h000, 32'h3f, 32'h0);
    apb(1'h1, 12'h018, 32'h0, 32'h0);
    apb(1'h1, 12'h01c, 32'h1, 32'h0);
    for (i = 1; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      cfg(i[1:0], seed[2:0] & ((i == 1) ? 3'h7 : (i == 2) ? 3'h6 : 3'h4),
        seed[8:3], 2'h0, 3'h0, 6'h0);
      len = 17'h1000 << i;
      st = {b1, 13'h0} & ~(len[15:0] - 16'h1);
      chka(st | (seed[31:16] & (len[15:0] - 16'h1)), 1'h0, 1'h0);
      chka(st | (len[15:0] - 16'h1), 1'h0, 1'h0);
      chka(st + len[15:0], 1'h0, 1'h0);
    end
    $display("window sizes done");
    split_14 <= 1'h1;
    cfg(2'h3, 3'h2, 6'h14, 2'h0, 3'h0, 6'h0);
    for (i = 0; i < 5; i = i + 1) begin
      chka(A4K[i*16 +: 16], 1'h0, 1'h0);
    end
    split_14 <= 1'h0;
    $display("window at 4000 done");
    cfg(2'h1, 3'h4, 6'h05, 2'h3, 3'h4, 6'h2c);
    chka(16'h8123, 1'h0, 1'h0);
    chka(16'ha456, 1'h0, 1'h0);
    chka(16'h8100, 1'h1, 1'h0);
    chka(16'h8100, 1'h0, 1'h1);
    chka(16'ha000, 1'h0, 1'h1);
    $display("overlap done");
    cfg(2'h0, 3'h0, 6'h0, 2'h0, 3'h0, 6'h0);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'h1, 12'h01c, {28'h0, VCTL[i*4 +: 4]}, 32'h0);
      chk(16'hfffe, 1'h1, 1'h0, 1'h1, 20'h00e07, VEXP[i*12 +: 12]);
    end
    $display("reset vector done");
    pa = 6'h0f;
    gdir = 6'h30;
    gdata = 6'h2a;
    apb(1'h1, 12'h000, 32'h0f, 32'h0);
    apb(1'h1, 12'h018, 32'h30, 32'h0);
    apb(1'h1, 12'h014, 32'h2a, 32'h0);
    chka(16'h6000, 1'h0, 1'h0);
    repeat (4) @(posedge ref_clk);
    apb(1'h0, 12'h020, 32'h0, 32'h23);
    $display("port pins done");
    summarize;
  end
endmodule

//--- test/pmwm_chk_sva.sv
`timescale 1ns/1ps
// ****************************************************
// mapper port checker
// ****************************************************
module pmwm_chk (
  input wire ref_clk,          // clock
  input wire nrst,             // sync reset, low
  input wire psel,             // apb select
  input wire penable,          // apb access phase
  input wire [11:0] paddr,     // apb address
  input wire pready,           // apb ready
  input wire [31:0] prdata,    // apb read data
  input wire pslverr,          // apb error
  input wire [15:0] cpu_addr,  // cpu address
  input wire vector_fetch,     // reset vector fetch
  input wire int_space_hit,    // internal resource here
  input wire rom_space_hit,    // rom here
  input wire [15:0] ext_addr,  // external address
  input wire int_sel,          // internal answers
  input wire rom_sel,          // rom answers
  input wire ext_sel,          // external answers
  input wire win1_active,      // window 1 owns
  input wire win2_active,      // window 2 owns
  input wire [5:0] pg_oe       // pin enables
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // apb phases
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  sequence bad_setup;
    psel && !penable && paddr > 12'h020;
  endsequence
  a_ready_now: assert property (
    apb_setup ##1 apb_access |-> pready)
    else $error("apb access not ready at once");
  a_bad_addr: assert property (
    bad_setup ##1 apb_access |-> pslverr && prdata == 32'h0)
    else $error("unmapped access without error");
  a_read_stands: assert property (
    apb_access ##1 !psel |-> $stable(prdata))
    else $error("read data moved while idle");
  a_win_excl: assert property (!(win1_active && win2_active))
    else $error("both windows own the access");
  a_one_sel: assert property (
    $onehot({int_sel, rom_sel, ext_sel}))
    else $error("not exactly one responder");
  a_int_wins: assert property (
    int_space_hit && !vector_fetch |-> int_sel)
    else $error("internal resource lost its address");
  a_win_ext: assert property (
    (win1_active || win2_active) && !int_space_hit && !rom_space_hit
    && !vector_fetch |-> ext_sel)
    else $error("window access not external");
  a_low_addr: assert property (
    !vector_fetch |-> ext_addr[12:0] == cpu_addr[12:0])
    else $error("in-bank offset altered");
  a_no_win: assert property (
    !win1_active && !win2_active && !vector_fetch |->
    ext_addr == cpu_addr)
    else $error("address changed outside windows");
  a_vec_addr: assert property (
    vector_fetch && ext_sel |->
    ext_addr[15:1] == 15'h3fff || ext_addr[15:1] == 15'h7fff)
    else $error("vector fetched from wrong place");
  a_reset_oe: assert property ($rose(nrst) |-> pg_oe == 6'h00)
    else $error("pins driven after reset");
endmodule
bind pmwm_mapper pmwm_chk i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cpu_addr(cpu_addr),
  .vector_fetch(vector_fetch), .int_space_hit(int_space_hit),
  .rom_space_hit(rom_space_hit), .ext_addr(ext_addr),
  .int_sel(int_sel), .rom_sel(rom_sel), .ext_sel(ext_sel),
  .win1_active(win1_active), .win2_active(win2_active), .pg_oe(pg_oe));

//--- test/pmwm_ext_mem.sv
`timescale 1ns/1ps
// ****************************************************
// banked external memory at the port pins
// ****************************************************
module pmwm_ext_mem (
  input wire ref_clk,          // clock
  input wire [15:0] ext_addr,  // bus address
  input wire [5:0] pg_out,     // pins from mapper
  input wire [5:0] pg_oe,      // mapper drive enables
  input wire split_14,         // board wired for 4000 window
  output wire [5:0] pg_in,     // pin levels back
  output wire [18:0] phys_addr // address at memory
);
  reg [5:0] park = 6'h15; // undriven pins: changing pattern
  // no pull on pins, so a free pin never holds a level
  always @(posedge ref_clk) begin
    park <= ~park;
  end
  assign pg_in = (pg_out & pg_oe) | (park & ~pg_oe);
  assign phys_addr = {pg_out[5:2], split_14 ? pg_out[1] : ext_addr[14],
    ext_addr[13:0]};
endmodule
